// ===== core/tlss_consts.vh
// Constants for the torque limit and stop selector
`ifndef TLSS_CONSTS_VH
`define TLSS_CONSTS_VH
// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define TLSS_LIM_W          9
`define TLSS_LIM_MAX        9'h12C
`define TLSS_SECOND_RST     9'h12C
`define TLSS_THIRD_RST      9'h12C
`define TLSS_STOP_ACT_RST   3'h5
`define TLSS_ACT_FREE_RUN   3'h3
`define TLSS_ACT_EMG_STOP   3'h5
`define TLSS_ACT_EMG_STOP4  3'h4
`define TLSS_HOLD_NONE      2'h0
`define TLSS_HOLD_SECOND    2'h1
`define TLSS_HOLD_ANALOG    2'h2
`define TLSS_MODE_POS       2'h0
`define TLSS_MODE_SPD       2'h1
`define TLSS_MODE_TRQ       2'h2
`define TLSS_DEV_W          24
`define TLSS_DEV_LVL_RST    11'h096
`define TLSS_OLW_RST        7'h32
`define TLSS_OLW_MIN        7'h0A
`define TLSS_OLW_MAX        7'h64
`define TLSS_DEV_LVL_MIN    11'h001
`define TLSS_DEV_LVL_MAX    11'h3E8
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TLSS_CLK_HZ         20000000
`define TLSS_TICK_US        10000
`define TLSS_TICK_CYC       ((`TLSS_CLK_HZ / 1000000) * `TLSS_TICK_US)
`define TLSS_BRK_MAX        10'h3E7
`endif

// ===== core/tlss_sync.v
// Three-flop input synchroniser with agreement detection
`timescale 1ns/100ps
module tlss_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  genvar g;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // A bit moves only once the last two stages agree
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          q_o[g] <= 1'b0;
        end else if (ce_i && (s2_reg[g] == s3_reg[g])) begin
          q_o[g] <= s3_reg[g];
        end
      end
    end
  endgenerate
endmodule

// ===== core/tlss_top.v
// Torque limit selection and stop behaviour of a servo drive
// Summary of operation
// - Torque mode with source 0 uses forward and reverse limits
// - Stop, no selects: third or direction limit
// - Stop, select0: third or min(analog, direction)
// - Stop, select1: third or min(second, direction)
// - Stop, both: third or min(analog, second)
// - Source 1 always uses analog limit
// - Sudden stops use third limit, except on main power loss
// - Position mode holds deviation at contact stop
// - Hold limit chosen by selects and setting
// - Source 1, hold 2 uses torque reference
// - Three stop actions, default 5, modes 3/4/5
// - Major alarm always free-runs on deceleration
// - Keep torque for brake hold time
// - Brake output drops at servo-on off
// - Flying start captures speed on servo-on in speed mode
// - Speed capture also on the first servo-on after power-up
// - Undervoltage alarms only when enabled
// - Deviation overflow above programmed level in position mode
// - Overload warning at programmed percentage
// - Starred settings latch at power-up
// - Source selects selects or analog limit
// - Second and third limits 0 to 300
`timescale 1ns/100ps
`include "tlss_consts.vh"
module tlss_top #(
  parameter LW       = `TLSS_LIM_W,
  parameter DW       = `TLSS_DEV_W,
  parameter SW       = 16,
  parameter PPR      = 16'h1000,
  parameter TICK_CYC = `TLSS_TICK_CYC
) (
  input  wire          CLK_SYS_I,
  input  wire          SYS_RST_I,
  input  wire          CLK_EN_I,
  input  wire [1:0]    CTRL_MODE_I,
  input  wire          SERVO_ON_I,
  input  wire          FORCED_STOP_I,
  input  wire          OVERTRAVEL_LIMIT_INPUT_I,
  input  wire          LIMIT_SEL0_I,
  input  wire          LIMIT_SEL1_I,
  input  wire          MINOR_ALARM_I,
  input  wire          MAJOR_ALARM_I,
  input  wire          MAIN_POWER_LOSS_I,
  input  wire          UNDERVOLTAGE_I,
  input  wire          DIR_CCW_I,
  input  wire [LW-1:0] FWD_LIMIT_I,
  input  wire [LW-1:0] REV_LIMIT_I,
  input  wire [LW-1:0] ANALOG_LIMIT_VALUE_I,
  input  wire [LW-1:0] ANALOG_TORQUE_REFERENCE_I,
  input  wire          TORQUE_LIMIT_SOURCE_I,
  input  wire [LW-1:0] SECOND_TORQUE_LIMIT_I,
  input  wire [1:0]    DEVIATION_HOLD_SELECT_I,
  input  wire [LW-1:0] THIRD_TORQUE_LIMIT_I,
  input  wire [2:0]    SERVO_OFF_STOP_ACTION_I,
  input  wire [2:0]    ALARM_STOP_ACTION_I,
  input  wire [2:0]    POWER_LOSS_STOP_ACTION_I,
  input  wire [9:0]    BRAKE_HOLD_TIME_I,
  input  wire          FLYING_START_ENABLE_I,
  input  wire          UNDERVOLTAGE_ALARM_ENABLE_I,
  input  wire [10:0]   DEVIATION_OVERFLOW_LEVEL_I,
  input  wire [6:0]    OVERLOAD_WARNING_LEVEL_I,
  input  wire [6:0]    OVERLOAD_LEVEL_I,
  input  wire [DW-1:0] POSITION_DEVIATION_I,
  input  wire [SW-1:0] MOTOR_SPEED_I,
  output reg  [LW-1:0] FWD_TORQUE_LIMIT_O,
  output reg  [LW-1:0] REV_TORQUE_LIMIT_O,
  output reg           DEVIATION_HOLD_O,
  output reg  [LW-1:0] HOLD_TORQUE_LIMIT_O,
  output reg           TORQUE_ENABLE_O,
  output reg           FREE_RUN_O,
  output reg           EMERGENCY_DECEL_O,
  output reg           BRAKE_RELEASE_O,
  output reg           SPEED_LOAD_O,
  output reg  [SW-1:0] SPEED_START_O,
  output reg           UNDERVOLTAGE_ALARM_O,
  output reg           DEVIATION_OVERFLOW_O,
  output reg           GENERAL_OUTPUT_SIGNAL_O
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [8:0] pin_q;
  tlss_sync #(
    .W (9)
  ) u_sync (
    .clk_i (CLK_SYS_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CLK_EN_I),
    .d_i   ({SERVO_ON_I, FORCED_STOP_I, OVERTRAVEL_LIMIT_INPUT_I, LIMIT_SEL0_I,
             LIMIT_SEL1_I, MINOR_ALARM_I, MAJOR_ALARM_I, MAIN_POWER_LOSS_I,
             UNDERVOLTAGE_I}),
    .q_o   (pin_q)
  );
  wire son   = pin_q[8];
  wire fstop = pin_q[7];
  wire ot    = pin_q[6];
  wire sel0  = pin_q[5];
  wire sel1  = pin_q[4];
  wire minor = pin_q[3];
  wire major = pin_q[2];
  wire ploss = pin_q[1];
  wire uv    = pin_q[0];

  // ----------------------------------------------------------------
  // Power-up latched settings
  // ----------------------------------------------------------------
  // Captured once after reset release; later edits wait for power cycle
  reg       latched_reg;
  reg       src_reg;
  reg [1:0] hold_sel_reg;
  reg [2:0] son_act_reg;
  reg [2:0] alm_act_reg;
  reg [2:0] pwr_act_reg;
  reg       fly_reg;
  reg       uv_en_reg;
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      latched_reg  <= 1'b0;
      src_reg      <= 1'b0;
      hold_sel_reg <= `TLSS_HOLD_NONE;
      son_act_reg  <= `TLSS_STOP_ACT_RST;
      alm_act_reg  <= `TLSS_STOP_ACT_RST;
      pwr_act_reg  <= `TLSS_STOP_ACT_RST;
      fly_reg      <= 1'b0;
      uv_en_reg    <= 1'b1;
    end else if (CLK_EN_I && !latched_reg) begin
      latched_reg  <= 1'b1;
      src_reg      <= TORQUE_LIMIT_SOURCE_I;
      hold_sel_reg <= DEVIATION_HOLD_SELECT_I;
      son_act_reg  <= SERVO_OFF_STOP_ACTION_I;
      alm_act_reg  <= ALARM_STOP_ACTION_I;
      pwr_act_reg  <= POWER_LOSS_STOP_ACTION_I;
      fly_reg      <= FLYING_START_ENABLE_I;
      uv_en_reg    <= UNDERVOLTAGE_ALARM_ENABLE_I;
    end
  end

  // ----------------------------------------------------------------
  // Limit clamping, common percent scale
  // ----------------------------------------------------------------
  function [LW-1:0] clamp;
    input [LW-1:0] v;
    begin
      clamp = (v > `TLSS_LIM_MAX) ? `TLSS_LIM_MAX : v;
    end
  endfunction
  function [LW-1:0] lmin;
    input [LW-1:0] a;
    input [LW-1:0] b;
    begin
      lmin = (a < b) ? a : b;
    end
  endfunction
  wire [LW-1:0] fwd  = clamp(FWD_LIMIT_I);
  wire [LW-1:0] rev  = clamp(REV_LIMIT_I);
  wire [LW-1:0] sec  = clamp(SECOND_TORQUE_LIMIT_I);
  wire [LW-1:0] thr  = clamp(THIRD_TORQUE_LIMIT_I);
  // Source 1 still reads the analog limit; the reference only feeds holding
  wire [LW-1:0] ana  = clamp(ANALOG_LIMIT_VALUE_I);
  // Hold uses the torque reference whenever source 1 and hold 2
  wire [LW-1:0] hana = (src_reg && hold_sel_reg == `TLSS_HOLD_ANALOG)
                       ? clamp(ANALOG_TORQUE_REFERENCE_I) : ana;

  // ----------------------------------------------------------------
  // Stop sequencing
  // ----------------------------------------------------------------
  localparam ST_RUN  = 3'h0;
  localparam ST_DEC  = 3'h1;
  localparam ST_HOLD = 3'h2;
  localparam ST_FREE = 3'h3;
  localparam ST_OFF  = 3'h4;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  act_reg;
  reg  [2:0]  act_next;
  reg         third_reg;
  reg         third_next;
  reg         son_d_reg;
  reg  [31:0] tick_cnt_reg;
  reg  [9:0]  hold_cnt_reg;
  reg         powered_reg;
  wire        tick     = (tick_cnt_reg == TICK_CYC - 1);
  wire        torq_md  = (CTRL_MODE_I == `TLSS_MODE_TRQ);
  wire        son_fall = son_d_reg && !son;
  wire        son_rise = !son_d_reg && son;
  wire [9:0]  brk_time = (BRAKE_HOLD_TIME_I > `TLSS_BRK_MAX) ? `TLSS_BRK_MAX
                                                            : BRAKE_HOLD_TIME_I;
  wire        hold_done = (hold_cnt_reg >= brk_time);

  always @* begin
    state_next = state_reg;
    act_next   = act_reg;
    third_next = third_reg;
    case (state_reg)
      ST_RUN: begin
        if (major) begin
          state_next = ST_FREE;
        end else if (ploss) begin
          act_next   = pwr_act_reg;
          third_next = 1'b0;
          state_next = (pwr_act_reg == `TLSS_ACT_FREE_RUN) ? ST_FREE : ST_DEC;
        end else if (minor) begin
          act_next   = alm_act_reg;
          third_next = (alm_act_reg == `TLSS_ACT_EMG_STOP4) ||
                       (alm_act_reg == `TLSS_ACT_EMG_STOP);
          state_next = (alm_act_reg == `TLSS_ACT_FREE_RUN) ? ST_FREE : ST_DEC;
        end else if (!son) begin
          act_next   = son_act_reg;
          third_next = 1'b1;
          state_next = (son_act_reg == `TLSS_ACT_FREE_RUN) ? ST_FREE : ST_HOLD;
        end else if (!fstop || !ot) begin
          act_next   = `TLSS_ACT_EMG_STOP;
          third_next = 1'b1;
          state_next = ST_DEC;
        end
      end
      ST_DEC: begin
        if (major) begin
          state_next = ST_FREE;
        end else if (son && fstop && ot && !minor && !ploss) begin
          state_next = ST_RUN;
        end else if (!son) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Torque kept while the brake engages
        if (major) begin
          state_next = ST_FREE;
        end else if (hold_done) begin
          state_next = ST_FREE;
        end
      end
      ST_FREE: begin
        if (son && !major && !minor && !ploss) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_FREE;
      end
    endcase
  end

  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_reg    <= ST_OFF;
      act_reg      <= `TLSS_STOP_ACT_RST;
      third_reg    <= 1'b0;
      son_d_reg    <= 1'b0;
      tick_cnt_reg <= 32'h0;
      hold_cnt_reg <= 10'h000;
      powered_reg  <= 1'b0;
    end else if (CLK_EN_I) begin
      state_reg   <= state_next;
      act_reg     <= act_next;
      third_reg   <= third_next;
      son_d_reg   <= son;
      powered_reg <= powered_reg | (state_reg != ST_OFF);
      if (state_reg != ST_HOLD || tick) begin
        tick_cnt_reg <= 32'h0;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
      if (state_reg != ST_HOLD) begin
        hold_cnt_reg <= 10'h000;
      end else if (tick && !hold_done) begin
        hold_cnt_reg <= hold_cnt_reg + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Torque limit selection
  // ----------------------------------------------------------------
  reg [LW-1:0] fwd_sel;
  reg [LW-1:0] rev_sel;
  reg          stopping;
  always @* begin
    stopping = (state_reg == ST_DEC) || (state_reg == ST_HOLD);
    fwd_sel  = fwd;
    rev_sel  = rev;
    if (src_reg) begin
      fwd_sel = ana;
      rev_sel = ana;
    end else if (torq_md) begin
      fwd_sel = fwd;
      rev_sel = rev;
    end else if (stopping && third_reg) begin
      case ({sel1, sel0})
        2'b00: begin
          fwd_sel = (fwd >= thr) ? thr : fwd;
          rev_sel = (rev >= thr) ? thr : rev;
        end
        2'b01: begin
          fwd_sel = (ana >= thr && fwd >= thr) ? thr : lmin(ana, fwd);
          rev_sel = (ana >= thr && rev >= thr) ? thr : lmin(ana, rev);
        end
        2'b10: begin
          fwd_sel = (sec >= thr && fwd >= thr) ? thr : lmin(sec, fwd);
          rev_sel = (sec >= thr && rev >= thr) ? thr : lmin(sec, rev);
        end
        default: begin
          fwd_sel = (ana >= thr && sec >= thr) ? thr : lmin(ana, sec);
          rev_sel = fwd_sel;
        end
      endcase
    end else begin
      case ({sel1, sel0})
        2'b00: begin
          fwd_sel = fwd;
          rev_sel = rev;
        end
        2'b01: begin
          fwd_sel = lmin(ana, fwd);
          rev_sel = lmin(ana, rev);
        end
        2'b10: begin
          fwd_sel = lmin(sec, fwd);
          rev_sel = lmin(sec, rev);
        end
        default: begin
          fwd_sel = lmin(ana, sec);
          rev_sel = fwd_sel;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Deviation hold
  // ----------------------------------------------------------------
  reg          hold_on;
  reg [LW-1:0] hold_lim;
  always @* begin
    hold_on  = 1'b0;
    hold_lim = {LW{1'b0}};
    if (CTRL_MODE_I == `TLSS_MODE_POS) begin
      case ({sel1, sel0})
        2'b01: begin
          hold_on  = (hold_sel_reg == `TLSS_HOLD_ANALOG);
          hold_lim = hana;
        end
        2'b10: begin
          hold_on  = (hold_sel_reg == `TLSS_HOLD_SECOND);
          hold_lim = sec;
        end
        2'b11: begin
          hold_on  = (hold_sel_reg == `TLSS_HOLD_SECOND) ||
                     (hold_sel_reg == `TLSS_HOLD_ANALOG);
          hold_lim = (hold_sel_reg == `TLSS_HOLD_SECOND) ? sec : hana;
        end
        default: begin
          hold_on  = 1'b0;
          hold_lim = {LW{1'b0}};
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Monitors: deviation overflow and overload warning
  // ----------------------------------------------------------------
  // Level in tenths of a revolution; scaled to counts
  wire [10:0] dev_lvl = (DEVIATION_OVERFLOW_LEVEL_I < `TLSS_DEV_LVL_MIN) ? `TLSS_DEV_LVL_MIN :
                        (DEVIATION_OVERFLOW_LEVEL_I > `TLSS_DEV_LVL_MAX) ? `TLSS_DEV_LVL_MAX :
                        DEVIATION_OVERFLOW_LEVEL_I;
  wire [47:0] dev_cnt10 = {37'h0, dev_lvl} * {32'h0, PPR[15:0]};
  wire [47:0] dev_abs10 = {24'h0, POSITION_DEVIATION_I[DW-1] ? (~POSITION_DEVIATION_I +
                          {{(DW-1){1'b0}}, 1'b1}) : POSITION_DEVIATION_I} * 48'hA;
  wire [6:0]  olw_lvl = (OVERLOAD_WARNING_LEVEL_I < `TLSS_OLW_MIN) ? `TLSS_OLW_MIN :
                        (OVERLOAD_WARNING_LEVEL_I > `TLSS_OLW_MAX) ? `TLSS_OLW_MAX :
                        OVERLOAD_WARNING_LEVEL_I;

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      FWD_TORQUE_LIMIT_O      <= {LW{1'b0}};
      REV_TORQUE_LIMIT_O      <= {LW{1'b0}};
      DEVIATION_HOLD_O        <= 1'b0;
      HOLD_TORQUE_LIMIT_O     <= {LW{1'b0}};
      TORQUE_ENABLE_O         <= 1'b0;
      FREE_RUN_O              <= 1'b1;
      EMERGENCY_DECEL_O       <= 1'b0;
      BRAKE_RELEASE_O         <= 1'b0;
      SPEED_LOAD_O            <= 1'b0;
      SPEED_START_O           <= {SW{1'b0}};
      UNDERVOLTAGE_ALARM_O    <= 1'b0;
      DEVIATION_OVERFLOW_O    <= 1'b0;
      GENERAL_OUTPUT_SIGNAL_O <= 1'b0;
    end else if (CLK_EN_I) begin
      FWD_TORQUE_LIMIT_O   <= fwd_sel;
      REV_TORQUE_LIMIT_O   <= rev_sel;
      DEVIATION_HOLD_O     <= hold_on;
      HOLD_TORQUE_LIMIT_O  <= hold_lim;
      TORQUE_ENABLE_O      <= (state_next == ST_RUN) || (state_next == ST_DEC) ||
                              (state_next == ST_HOLD);
      FREE_RUN_O           <= (state_next == ST_FREE) || (state_next == ST_OFF);
      EMERGENCY_DECEL_O    <= (state_next == ST_DEC) && (act_next != `TLSS_ACT_FREE_RUN);
      BRAKE_RELEASE_O      <= son && (state_next == ST_RUN);
      // Any servo-on rise in free-run in speed mode picks up speed, the first start included
      SPEED_LOAD_O         <= son_rise && fly_reg && powered_reg &&
                              (state_reg == ST_FREE) &&
                              (CTRL_MODE_I == `TLSS_MODE_SPD);
      if (son_rise && state_reg == ST_FREE) begin
        SPEED_START_O <= MOTOR_SPEED_I;
      end
      UNDERVOLTAGE_ALARM_O <= uv_en_reg && uv;
      DEVIATION_OVERFLOW_O <= (CTRL_MODE_I == `TLSS_MODE_POS) &&
                              (dev_abs10 > dev_cnt10);
      GENERAL_OUTPUT_SIGNAL_O <= (OVERLOAD_LEVEL_I >= olw_lvl);
    end
  end
  // Brake hold length is clamped to TLSS_BRK_MAX, 999 ticks
  wire unused_fall = son_fall;
endmodule

// ===== dv/tlss_motor_model.sv
// Behavioural motor shaft and holding brake facing the drive outputs
`timescale 1ns/100ps
module tlss_motor_model #(
  parameter BRK_DLY = 6
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        trq_en_i,
  input  wire        brake_release_i,
  output reg  [15:0] speed_o,
  output reg         brake_set_o
);
  reg [3:0] dly_reg;
  // ----------------------------------------------------------------
  // Brake shoe bites BRK_DLY+1 cycles after the release line drops
  // ----------------------------------------------------------------
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly_reg     <= 4'h0;
      brake_set_o <= 1'b1;
    end else if (brake_release_i) begin
      dly_reg     <= 4'h0;
      brake_set_o <= 1'b0;
    end else if (dly_reg < BRK_DLY) begin
      dly_reg <= dly_reg + 4'h1;
    end else begin
      brake_set_o <= 1'b1;
    end
  end
  // Shaft speeds up under torque and coasts down without it
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      speed_o <= 16'h0000;
    else if (trq_en_i && speed_o < 16'h0400)
      speed_o <= speed_o + 16'h0010;
    else if (!trq_en_i && speed_o != 16'h0000)
      speed_o <= speed_o - 16'h0001;
  end
endmodule

// ===== dv/tlss_assertions.sv
// Concurrent checks on the torque limit and stop selector ports
`timescale 1ns/100ps
module tlss_checker #(
  parameter LW  = 9,
  parameter DW  = 24,
  parameter PPR = 16'h1000
) (
  input wire          CLK_SYS_I,
  input wire          SYS_RST_I,
  input wire [1:0]    CTRL_MODE_I,
  input wire          SERVO_ON_I,
  input wire          UNDERVOLTAGE_I,
  input wire [LW-1:0] FWD_LIMIT_I,
  input wire [LW-1:0] ANALOG_LIMIT_VALUE_I,
  input wire          TORQUE_LIMIT_SOURCE_I,
  input wire [9:0]    BRAKE_HOLD_TIME_I,
  input wire          UNDERVOLTAGE_ALARM_ENABLE_I,
  input wire [10:0]   DEVIATION_OVERFLOW_LEVEL_I,
  input wire [6:0]    OVERLOAD_WARNING_LEVEL_I,
  input wire [6:0]    OVERLOAD_LEVEL_I,
  input wire [DW-1:0] POSITION_DEVIATION_I,
  input wire [LW-1:0] FWD_TORQUE_LIMIT_O,
  input wire          TORQUE_ENABLE_O,
  input wire          BRAKE_RELEASE_O,
  input wire          UNDERVOLTAGE_ALARM_O,
  input wire          DEVIATION_OVERFLOW_O,
  input wire          GENERAL_OUTPUT_SIGNAL_O
);
  reg  [1:0]  up_reg;
  wire        up = (up_reg == 2'h3);
  wire [39:0] dev_x = {16'h0, POSITION_DEVIATION_I} * 40'hA;
  wire [39:0] lvl_x = {29'h0, DEVIATION_OVERFLOW_LEVEL_I} * PPR;
  // Settings latch just after reset, so checks wait for them to settle
  always @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I)
      up_reg <= 2'h0;
    else if (!up)
      up_reg <= up_reg + 2'h1;
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  a_torque_mode: assert property (
    up && CTRL_MODE_I == 2'h2 && !TORQUE_LIMIT_SOURCE_I && FWD_LIMIT_I <= 9'h12C
    |=> FWD_TORQUE_LIMIT_O == $past(FWD_LIMIT_I)) else $error("torque mode limit");
  a_analog_src: assert property (
    up && TORQUE_LIMIT_SOURCE_I && ANALOG_LIMIT_VALUE_I <= 9'h12C
    |=> FWD_TORQUE_LIMIT_O == $past(ANALOG_LIMIT_VALUE_I)) else $error("analog limit");
  a_brake_drop: assert property (
    $fell(SERVO_ON_I) |-> ##[1:8] !BRAKE_RELEASE_O) else $error("brake not applied");
  a_torque_kept: assert property (
    $fell(BRAKE_RELEASE_O) && !SERVO_ON_I && BRAKE_HOLD_TIME_I >= 10'h2
    |-> TORQUE_ENABLE_O [*4]) else $error("torque dropped early");
  a_uv_raise: assert property (
    (up && UNDERVOLTAGE_ALARM_ENABLE_I && UNDERVOLTAGE_I) [*8]
    |-> UNDERVOLTAGE_ALARM_O) else $error("undervoltage alarm missing");
  a_uv_quiet: assert property (
    up && !UNDERVOLTAGE_ALARM_ENABLE_I |-> !UNDERVOLTAGE_ALARM_O) else $error("uv alarm");
  a_warn_level: assert property (
    (OVERLOAD_WARNING_LEVEL_I >= 7'hA && OVERLOAD_WARNING_LEVEL_I <= 7'h64
     && OVERLOAD_LEVEL_I >= OVERLOAD_WARNING_LEVEL_I) [*4]
    |-> GENERAL_OUTPUT_SIGNAL_O) else $error("overload warning missing");
  a_dev_ovf: assert property (
    (up && CTRL_MODE_I == 2'h0 && !POSITION_DEVIATION_I[DW-1] && dev_x > lvl_x) [*4]
    |-> DEVIATION_OVERFLOW_O) else $error("deviation overflow missing");
  c_servo_off: cover property ($fell(SERVO_ON_I));
  c_uv: cover property (UNDERVOLTAGE_ALARM_O);
  c_ovf: cover property (DEVIATION_OVERFLOW_O);
endmodule
bind tlss_top tlss_checker #(.LW(LW), .DW(DW), .PPR(PPR)) i_tlss_checker (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .CTRL_MODE_I(CTRL_MODE_I),
  .SERVO_ON_I(SERVO_ON_I), .UNDERVOLTAGE_I(UNDERVOLTAGE_I), .FWD_LIMIT_I(FWD_LIMIT_I),
  .ANALOG_LIMIT_VALUE_I(ANALOG_LIMIT_VALUE_I), .TORQUE_LIMIT_SOURCE_I(TORQUE_LIMIT_SOURCE_I),
  .BRAKE_HOLD_TIME_I(BRAKE_HOLD_TIME_I),
  .UNDERVOLTAGE_ALARM_ENABLE_I(UNDERVOLTAGE_ALARM_ENABLE_I),
  .DEVIATION_OVERFLOW_LEVEL_I(DEVIATION_OVERFLOW_LEVEL_I),
  .OVERLOAD_WARNING_LEVEL_I(OVERLOAD_WARNING_LEVEL_I), .OVERLOAD_LEVEL_I(OVERLOAD_LEVEL_I),
  .POSITION_DEVIATION_I(POSITION_DEVIATION_I), .FWD_TORQUE_LIMIT_O(FWD_TORQUE_LIMIT_O),
  .TORQUE_ENABLE_O(TORQUE_ENABLE_O), .BRAKE_RELEASE_O(BRAKE_RELEASE_O),
  .UNDERVOLTAGE_ALARM_O(UNDERVOLTAGE_ALARM_O), .DEVIATION_OVERFLOW_O(DEVIATION_OVERFLOW_O),
  .GENERAL_OUTPUT_SIGNAL_O(GENERAL_OUTPUT_SIGNAL_O));

// ===== dv/tb_top.sv
// Self-checking bench for the torque limit and stop selector
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  reg         clk, ce, rst, son, fst, ot, s0, s1, mna, mja, uv, src, uve;
  reg  [1:0]  md, hs;
  reg  [8:0]  fw, rv, an, tr, sc, th;
  reg  [2:0]  soa, ala;
  reg  [9:0]  bht;
  reg  [10:0] dol;
  reg  [6:0]  owl, ovl;
  reg  [23:0] dev;
  wire [8:0]  fo, ro;
  wire        te, fr, br, ua, dov, ow, bset;
  wire [15:0] spd;
  int         failures, n_tests, cyc, i, k;
  tlss_top #(.TICK_CYC(4)) i_tlss_top (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .CLK_EN_I(ce), .CTRL_MODE_I(md),
    .SERVO_ON_I(son), .FORCED_STOP_I(fst), .OVERTRAVEL_LIMIT_INPUT_I(ot),
    .LIMIT_SEL0_I(s0), .LIMIT_SEL1_I(s1), .MINOR_ALARM_I(mna), .MAJOR_ALARM_I(mja),
    .MAIN_POWER_LOSS_I(1'b0), .UNDERVOLTAGE_I(uv), .DIR_CCW_I(1'b0), .FWD_LIMIT_I(fw),
    .REV_LIMIT_I(rv), .ANALOG_LIMIT_VALUE_I(an), .ANALOG_TORQUE_REFERENCE_I(tr),
    .TORQUE_LIMIT_SOURCE_I(src), .SECOND_TORQUE_LIMIT_I(sc), .DEVIATION_HOLD_SELECT_I(hs),
    .THIRD_TORQUE_LIMIT_I(th), .SERVO_OFF_STOP_ACTION_I(soa), .ALARM_STOP_ACTION_I(ala),
    .POWER_LOSS_STOP_ACTION_I(3'h5), .BRAKE_HOLD_TIME_I(bht), .FLYING_START_ENABLE_I(1'b0),
    .UNDERVOLTAGE_ALARM_ENABLE_I(uve), .DEVIATION_OVERFLOW_LEVEL_I(dol),
    .OVERLOAD_WARNING_LEVEL_I(owl), .OVERLOAD_LEVEL_I(ovl), .POSITION_DEVIATION_I(dev),
    .MOTOR_SPEED_I(spd), .FWD_TORQUE_LIMIT_O(fo), .REV_TORQUE_LIMIT_O(ro),
    .DEVIATION_HOLD_O(), .HOLD_TORQUE_LIMIT_O(), .TORQUE_ENABLE_O(te), .FREE_RUN_O(fr),
    .EMERGENCY_DECEL_O(), .BRAKE_RELEASE_O(br), .SPEED_LOAD_O(), .SPEED_START_O(),
    .UNDERVOLTAGE_ALARM_O(ua), .DEVIATION_OVERFLOW_O(dov), .GENERAL_OUTPUT_SIGNAL_O(ow));
  tlss_motor_model i_tlss_motor_model (.clk_i(clk), .rst_i(rst), .trq_en_i(te),
    .brake_release_i(br), .speed_o(spd), .brake_set_o(bset));
  function automatic [8:0] mn(input [8:0] a, input [8:0] b);
    mn = (a < b) ? a : b;
  endfunction
  // Stop limit is the least of the third limit and the pair the selects pick
  function automatic [8:0] stop_lim(input [1:0] s, input [8:0] d);
    case (s)
      2'h0: stop_lim = mn(th, d);
      2'h1: stop_lim = mn(th, mn(an, d));
      2'h2: stop_lim = mn(th, mn(sc, d));
      default: stop_lim = mn(th, mn(an, sc));
    endcase
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    wt(5);
    `CHK(fr, 1'b1)
    `CHK(br, 1'b0)
    `CHK(te, 1'b0)
    @(posedge clk);
    rst <= 1'b0;
    wt(12);
  endtask
  task automatic uv_chk;
    @(posedge clk);
    uv <= 1'b1;
    wt(8);
    `CHK(ua, uve)
    @(posedge clk);
    uv <= 1'b0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    {ce, rst, son, fst, ot, s0, s1, mna, mja, uv, src, uve} = 12'hF81;
    {md, hs} = 4'h0;
    {fw, rv, an, tr, sc, th} = {6{9'h12C}};
    {soa, ala} = 6'h2D;
    bht = 10'h3;
    dol = 11'h096;
    owl = 7'h32;
    ovl = 7'h00;
    dev = 24'h0;
    {failures, n_tests, cyc} = 0;
    k = $urandom(55134);
    do_reset;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      fw <= $urandom % 301;
      rv <= $urandom % 301;
      {s1, s0} <= $urandom;
      md <= 2'h2;
      wt(2);
      `CHK(fo, fw)
      `CHK(ro, rv)
    end
    // Servo off: brake closes within nine cycles, torque holds for three short ticks
    @(posedge clk);
    md <= 2'h0;
    wt(2);
    `CHK(br, 1'b1)
    @(posedge clk);
    son <= 1'b0;
    for (k = 0; br === 1'b1 && k < 10; k++)
      wt(0);
    `CHK(k < 9, 1'b1)
    `CHK(te, 1'b1)
    for (k = 0; fr !== 1'b1 && k < 30; k++)
      wt(0);
    `CHK(k >= 7 && k <= 17, 1'b1)
    `CHK(te, 1'b0)
    `CHK(bset, 1'b1)
    @(posedge clk);
    son <= 1'b1;
    wt(12);
    @(posedge clk);
    fst <= 1'b0;
    wt(8);
    for (i = 0; i < 24; i++) begin
      @(posedge clk);
      fw <= i < 4 ? 9'h12C : $urandom % 301;
      rv <= i < 4 ? 9'h12C : $urandom % 301;
      an <= i < 4 ? 9'h12C : $urandom % 301;
      sc <= i < 4 ? 9'h12C : $urandom % 301;
      th <= i < 4 ? 9'h12C : $urandom % 301;
      {s1, s0} <= i[1:0];
      wt(6);
      `CHK(fo, stop_lim(i[1:0], fw))
      `CHK(ro, stop_lim(i[1:0], rv))
    end
    @(posedge clk);
    fst <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      k = 10 + $urandom % 91;
      owl <= k;
      ovl <= (i % 3 == 0) ? k : $urandom % 128;
      wt(4);
      `CHK(ow, ovl >= owl)
    end
    @(posedge clk);
    mja <= 1'b1;
    wt(6);
    `CHK(fr, 1'b1)
    `CHK(te, 1'b0)
    @(posedge clk);
    mja <= 1'b0;
    // Deviation exactly at the level must not trip, one count above must
    @(posedge clk);
    k = 1 + $urandom % 1000;
    dol <= k;
    dev <= k * 4096 / 10;
    wt(6);
    `CHK(dov, 1'b0)
    @(posedge clk);
    dev <= k * 4096 / 10 + 1;
    wt(6);
    `CHK(dov, 1'b1)
    uv_chk;
    @(posedge clk);
    rst <= 1'b1;
    src <= 1'b1;
    uve <= 1'b0;
    dev <= 24'h0;
    do_reset;
    uv_chk;
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      an <= $urandom % 301;
      md <= $urandom % 3;
      {s1, s0} <= $urandom;
      wt(2);
      `CHK(fo, an)
      `CHK(ro, an)
    end
    complete_run;
  end
endmodule
